// file: common/boot_loader_pkg.sv
// constants, carriers and state codes for the coefficient boot loader
// assumes a 40 MHz mclk and a byte-wide register port
package boot_loader_pkg;

	// clock rates
	localparam int unsigned MCLK_HZ = 40_000_000;
	localparam int unsigned SCK_HZ_R0 = 1_250_000;
	localparam int unsigned SCK_HZ_R1 = 2_500_000;
	localparam int unsigned SCK_HZ_R2 = 5_000_000;
	localparam int unsigned SCK_HZ_R3 = 10_000_000;
	// half period of the serial clock in mclk cycles, minus one (reload value)
	localparam logic [4:0] HALF_R0 = 5'(MCLK_HZ / (2 * SCK_HZ_R0) - 1);
	localparam logic [4:0] HALF_R1 = 5'(MCLK_HZ / (2 * SCK_HZ_R1) - 1);
	localparam logic [4:0] HALF_R2 = 5'(MCLK_HZ / (2 * SCK_HZ_R2) - 1);
	localparam logic [4:0] HALF_R3 = 5'(MCLK_HZ / (2 * SCK_HZ_R3) - 1);

	// register offsets
	localparam logic [7:0] ADDR_SERIAL_CLOCK_SELECT = 8'h55;
	localparam logic [7:0] ADDR_BOOT_LOAD_CONTROL = 8'h56;
	localparam logic [7:0] ADDR_BOOT_READ_OPCODE = 8'h57;
	localparam logic [7:0] ADDR_BOOT_START_ADDR_HIGH = 8'h58;
	localparam logic [7:0] ADDR_BOOT_START_ADDR_MID = 8'h59;
	localparam logic [7:0] ADDR_BOOT_START_ADDR_LOW = 8'h5a;
	localparam logic [7:0] ADDR_BOOT_LOAD_STATUS = 8'h5b;

	// reset values
	localparam logic [7:0] RST_SERIAL_CLOCK_SELECT = 8'h00;
	localparam logic [7:0] RST_BOOT_LOAD_CONTROL = 8'h00;
	localparam logic [7:0] RST_BOOT_READ_OPCODE = 8'h03;
	localparam logic [7:0] RST_BOOT_START_ADDR = 8'h00;

	// field positions
	localparam int CLK_SEL_LSB = 0;
	localparam int CLK_SEL_W = 4;
	localparam int CTRL_WIDE_BIT = 5;
	localparam int CTRL_RATE_LSB = 3;
	localparam int CTRL_EDGE_BIT = 2;
	localparam int CTRL_ORDER_BIT = 1;
	localparam int CTRL_SRC_BIT = 0;
	localparam int CTRL_USED_W = 6;
	localparam int STAT_CRC_BIT = 1;
	localparam int STAT_DONE_BIT = 0;

	// coefficient image: data bytes followed by one crc-8 byte
	localparam logic [15:0] IMAGE_LEN = 16'h0040;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// buffer shape
	localparam int COEF_W = 8;
	localparam int FIFO_DEPTH = 8;

	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	// serial pins driven by the loader
	typedef struct packed {
		logic sck;
		logic cs_n;
		logic mosi;
	} spi_pins_s;

	typedef enum logic [2:0] {
		LD_IDLE = 3'b000,
		LD_SEND = 3'b001,
		LD_RECV = 3'b010,
		LD_HOLD = 3'b011,
		LD_FINISH = 3'b100
	} ld_state_e;

endpackage : boot_loader_pkg

// file: dv/boot_loader_asserts.sv
// checker: serial timing, start and abort, register read-back
// assumes it is bound to the loader top and sees every register write
`timescale 1ns/1ps
module boot_loader_asserts
	import boot_loader_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire reg_req_s reg_req,
	input wire logic [7:0] reg_rdata,
	input wire spi_pins_s spi_out,
	input wire logic coef_from_eeprom,
	input wire logic coef_valid,
	input wire logic coef_ready
);
	logic [7:0] sh_q [7];
	logic [7:0] half_q;
	logic [7:0] hi_q;
	logic ctl_wr;
	assign ctl_wr = reg_req.wr && reg_req.addr == ADDR_BOOT_LOAD_CONTROL;
	always_ff @(posedge mclk)
	begin
		if (rst)
			sh_q <= '{8'h00, 8'h00, RST_BOOT_READ_OPCODE, 8'h00, 8'h00, 8'h00, 8'h00};
		else if (reg_req.wr && reg_req.addr inside {[8'h55:8'h5a]})
			sh_q[3'(reg_req.addr - 8'h55)] <= reg_req.wdata;
		if ($fell(spi_out.cs_n))
			half_q <= 8'h10 >> sh_q[1][4:3];
		hi_q <= spi_out.sck ? hi_q + 8'h01 : 8'h00;
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	a_sck_half_rate: assert property ($fell(spi_out.sck) && !spi_out.cs_n && sh_q[1][0]
		|-> hi_q == half_q) else $error("sck high time wrong");
	a_idle_quiet: assert property (spi_out.cs_n |-> !spi_out.sck && !spi_out.mosi)
		else $error("serial lines busy while deselected");
	a_start_select: assert property (ctl_wr && reg_req.wdata[0] && !sh_q[1][0] && spi_out.cs_n
		|-> ##3 !spi_out.cs_n) else $error("load did not start");
	a_source_copy: assert property (coef_from_eeprom == $past(sh_q[1][0]))
		else $error("source level wrong");
	a_opcode_read: assert property (reg_req.rd && reg_req.addr == 8'h57
		|=> reg_rdata == $past(sh_q[2])) else $error("opcode read wrong");
	a_start_addr_read: assert property (reg_req.rd && reg_req.addr inside {[8'h58:8'h5a]}
		|=> reg_rdata == $past(sh_q[3'(reg_req.addr - 8'h55)])) else $error("address read wrong");
	a_status_loading: assert property (reg_req.rd && reg_req.addr == 8'h5b && !spi_out.cs_n
		|=> reg_rdata == 8'h00) else $error("status set during load");
	a_abort_release: assert property (ctl_wr && !reg_req.wdata[0] && !spi_out.cs_n
		|-> ##[1:8] spi_out.cs_n) else $error("abort did not release");
	c_load_end: cover property ($rose(spi_out.cs_n) && sh_q[1][0]);
	c_abort: cover property (ctl_wr && !reg_req.wdata[0] && !spi_out.cs_n);
	c_sink_stall: cover property ((coef_valid && !coef_ready) [*8]);
endmodule : boot_loader_asserts
bind eeprom_boot_loader boot_loader_asserts chk_u (.*);

// file: dv/eeprom_coefficient_boot_loader_tb.sv
// bench: registers, loads in several modes, crc error, sink stall, abort
// assumes the eeprom model and the bound checker
`timescale 1ns/1ps
module eeprom_coefficient_boot_loader_tb
	import boot_loader_pkg::*;
;
	logic mclk, rst, coef_clk, spi_miso, coef_from_eeprom, coef_valid, coef_ready;
	logic stall, edge_sel, lsb_first, wide;
	logic [7:0] reg_rdata, coef_data, crc_byte;
	logic [7:0] regv [4] = '{8'h03, 8'h00, 8'h00, 8'h00};
	logic [31:0] hdr_bits, nbits;
	logic [7:0] got_q [$];
	reg_req_s reg_req;
	spi_pins_s spi_out;
	int n_fail = 0;
	int num_checks = 0;
	eeprom_boot_loader dut_u (.*);
	eeprom_model mem_u (.sck(spi_out.sck), .cs_n(spi_out.cs_n), .mosi(spi_out.mosi),
		.edge_sel(edge_sel), .lsb_first(lsb_first), .wide(wide), .crc_byte(crc_byte),
		.miso(spi_miso), .hdr_q(hdr_bits), .nbits(nbits));
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial
	begin
		coef_clk = 1'b0;
		#37;
		forever #80 coef_clk = ~coef_clk;
	end
	always @(posedge coef_clk)
	begin
		if (coef_valid === 1'b1 && coef_ready === 1'b1)
			got_q.push_back(coef_data);
		coef_ready <= !stall;
	end
	function automatic logic [7:0] img(input int i);
		return 8'(i) * 8'h1d + 8'h07;
	endfunction : img
	function automatic logic [7:0] arr(input logic [7:0] b);
		return lsb_first ? {<<{b}} : b;
	endfunction : arr
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic timeout_if(input logic hit);
		if (hit)
		begin
			n_fail++;
			tally_and_finish();
		end
	endtask : timeout_if
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		reg_req.wr <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge mclk);
		reg_req.rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_rd
	task automatic wait_cs(input logic lvl, input int bound);
		for (int i = 0; i < bound && spi_out.cs_n !== lvl; i++)
			@(posedge mclk) #1;
		timeout_if(spi_out.cs_n !== lvl);
	endtask : wait_cs
	task automatic t_regs();
		logic [7:0] d;
		logic [7:0] a [7] = '{8'h55, 8'h57, 8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c};
		logic [7:0] e [7] = '{8'h0f, 8'ha5, 8'h12, 8'h34, 8'hc1, 8'h01, 8'h00};
		for (int i = 0; i < 7; i++)
			reg_wr(a[i], e[i] | 8'hf0 & {8{i == 0}});
		reg_wr(8'h5b, 8'hfe);
		for (int i = 0; i < 7; i++)
		begin
			reg_rd(a[i], d);
			check("read back", e[i], d);
		end
		regv = '{8'ha5, 8'h12, 8'h34, 8'hc1};
		$display("done regs");
	endtask : t_regs
	task automatic run_load(input logic [7:0] ctrl, input logic bad, input logic stall_on);
		logic [7:0] crc;
		logic [7:0] d;
		logic [31:0] n0;
		crc = CRC_INIT;
		for (int i = 0; i < IMAGE_LEN; i++)
		begin
			crc = crc ^ img(i);
			repeat (8)
				crc = crc[7] ? ((crc << 1) ^ CRC_POLY) : (crc << 1);
		end
		crc_byte = bad ? ~crc : crc;
		{wide, edge_sel, lsb_first} = {ctrl[5], ctrl[2], ctrl[1]};
		got_q.delete();
		stall = stall_on;
		reg_wr(ADDR_BOOT_LOAD_CONTROL, ctrl & 8'hfe);
		reg_wr(ADDR_BOOT_LOAD_CONTROL, ctrl);
		wait_cs(1'b0, 8);
		reg_rd(ADDR_BOOT_LOAD_STATUS, d);
		check("busy status", 8'h00, d);
		check("source level", 1'b1, coef_from_eeprom);
		if (stall_on)
		begin
			tick(5000);
			n0 = nbits;
			tick(600);
			check("stalled bit count", n0, nbits);
			stall = 1'b0;
		end
		wait_cs(1'b1, 40000);
		for (int i = 0; i < 2000 && got_q.size() < 64; i++)
			tick(1);
		timeout_if(got_q.size() != 64);
		reg_rd(ADDR_BOOT_LOAD_STATUS, d);
		check("end status", {6'h00, bad, 1'b1}, d);
		check("header", wide ? {arr(regv[0]), arr(regv[1]), arr(regv[2]), arr(regv[3])}
			: {8'h00, arr(regv[0]), arr(regv[2]), arr(regv[3])}, hdr_bits);
		check("bit count", wide ? 32'h0000_0228 : 32'h0000_0220, nbits);
		for (int i = 0; i < 64; i++)
			check("coef byte", img(i), got_q[i]);
	endtask : run_load
	task automatic t_abort();
		logic [7:0] d;
		reg_wr(ADDR_BOOT_LOAD_CONTROL, 8'h18);
		reg_wr(ADDR_BOOT_LOAD_CONTROL, 8'h19);
		wait_cs(1'b0, 8);
		tick(300);
		reg_wr(ADDR_BOOT_LOAD_CONTROL, 8'h18);
		wait_cs(1'b1, 10);
		reg_rd(ADDR_BOOT_LOAD_STATUS, d);
		check("abort status", 8'h00, d);
		check("source level", 1'b0, coef_from_eeprom);
		$display("done abort");
	endtask : t_abort
	initial
	begin
		logic [7:0] d;
		rst = 1'b1;
		reg_req = '0;
		{stall, edge_sel, lsb_first, wide, crc_byte} = '0;
		tick(12);
		rst <= 1'b0;
		for (int i = 0; i < 9; i++)
		begin
			reg_rd(8'h54 + 8'(i), d);
			check("reset value", (i == 3) ? 8'h03 : 8'h00, d);
		end
		$display("done reset values");
		run_load(8'h31, 1'b0, 1'b0);
		$display("done wide load");
		t_regs();
		run_load(8'h07, 1'b0, 1'b1);
		$display("done lsb stalled load");
		run_load(8'h29, 1'b1, 1'b0);
		$display("done crc error load");
		t_abort();
		tally_and_finish();
	end
endmodule : eeprom_coefficient_boot_loader_tb

// file: dv/eeprom_model.sv
// serial eeprom model: takes opcode and address, returns image then crc byte
// assumes the bench sets mode, order and width before each load
`timescale 1ns/1ps
module eeprom_model
	import boot_loader_pkg::*;
(
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic edge_sel,
	input wire logic lsb_first,
	input wire logic wide,
	input wire logic [7:0] crc_byte,
	output logic miso,
	output logic [31:0] hdr_q,
	output logic [31:0] nbits
);
	logic [31:0] hdr;
	logic [31:0] j;
	logic [7:0] cur;
	assign hdr = wide ? 32'h0000_0020 : 32'h0000_0018;
	initial
		miso = 1'b0;
	always @(negedge cs_n)
	begin
		hdr_q = 32'h0000_0000;
		nbits = 32'h0000_0000;
	end
	// released line shows the inverse of its last bit
	always @(posedge cs_n)
		miso = ~miso;
	always @(sck)
	begin
		j = nbits - hdr;
		cur = (j < 32'(IMAGE_LEN) * 8) ? 8'(j / 8) * 8'h1d + 8'h07 : crc_byte;
		if (!cs_n && (sck ^ edge_sel) && nbits >= hdr)
			miso = lsb_first ? cur[j % 8] : cur[7 - j % 8];
		else if (!cs_n && !(sck ^ edge_sel))
		begin
			if (nbits < hdr)
				hdr_q = {hdr_q[30:0], mosi};
			nbits = nbits + 1;
		end
	end
endmodule : eeprom_model

// file: rtl/coef_async_fifo.sv
// dual-clock fifo with gray pointers and a registered output stage
// assumes wr_rst is synchronous to wr_clk; rd side resynchronises it
`timescale 1ns/1ps
module coef_async_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic wr_clk,
	input wire logic wr_rst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	input wire logic rd_clk,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0] bin;
		logic [AW:0] gray;
		logic [AW:0] sync1;
		logic [AW:0] sync2;
	} wside_s;

	typedef struct packed {
		logic rst1;
		logic rst2;
		logic [AW:0] bin;
		logic [AW:0] gray;
		logic [AW:0] sync1;
		logic [AW:0] sync2;
		logic valid;
		logic [WIDTH-1:0] data;
	} rside_s;

	logic [WIDTH-1:0] mem [DEPTH];
	wside_s wq;
	wside_s wd;
	rside_s rq;
	rside_s rd;
	logic full;
	logic empty;
	logic [AW:0] wbin_n;
	logic [AW:0] rbin_n;

	// full when write pointer is one lap ahead of synchronised read pointer
	assign full = wq.gray == {~wq.sync2[AW:AW-1], wq.sync2[AW-2:0]};
	assign in_ready = ~full;
	assign wbin_n = wq.bin + {{AW{1'b0}}, 1'b1};

	always_comb
	begin
		wd = wq;
		wd.sync1 = rq.gray;
		wd.sync2 = wq.sync1;
		if (in_valid && !full)
		begin
			wd.bin = wbin_n;
			wd.gray = wbin_n ^ (wbin_n >> 1);
		end
	end

	always_ff @(posedge wr_clk)
	begin
		if (wr_rst)
			wq <= '0;
		else
			wq <= wd;
		if (in_valid && !full)
			mem[wq.bin[AW-1:0]] <= in_data;
	end

	assign empty = rq.gray == rq.sync2;
	assign rbin_n = rq.bin + {{AW{1'b0}}, 1'b1};

	always_comb
	begin
		rd = rq;
		rd.rst1 = wr_rst;
		rd.rst2 = rq.rst1;
		rd.sync1 = wq.gray;
		rd.sync2 = rq.sync1;
		if (rq.valid && out_ready)
			rd.valid = 1'b0;
		if (!empty && (!rq.valid || out_ready))
		begin
			rd.valid = 1'b1;
			rd.data = mem[rq.bin[AW-1:0]];
			rd.bin = rbin_n;
			rd.gray = rbin_n ^ (rbin_n >> 1);
		end
	end

	always_ff @(posedge rd_clk)
	begin
		if (rq.rst2)
		begin
			rq <= '0;
			rq.rst1 <= rd.rst1;
			rq.rst2 <= rd.rst2;
		end
		else
			rq <= rd;
	end

	assign out_valid = rq.valid;
	assign out_data = rq.data;

endmodule : coef_async_fifo

// file: rtl/eeprom_boot_loader.sv
// serial eeprom coefficient boot loader: registers, spi master, crc check
// assumes a byte register port on mclk and a coefficient sink on coef_clk
//
// Operation
// - the serial clock runs at 1.25, 2.5, 5 or 10 MHz as the 2-bit rate field selects.
// - with shift edge select clear data changes on the rising clock edge, set on the falling.
// - bit order select clear sends and receives msb first, set lsb first.
// - with wide address enable set the start address goes out as three bytes.
// - source select set loads coefficients from the eeprom, clear leaves them to the host.
// - the read opcode comes from an 8-bit register that resets to 0x03.
// - the high start address byte comes from its own register, reset zero.
// - the middle start address byte comes from its own register, reset zero.
// - the low start address byte comes from its own register, reset zero.
// - a read-only flag shows zero when the image crc passes and one when it fails.
// - bit 0 of the status register is set when the boot load finishes and resets to zero.
`timescale 1ns/1ps
module eeprom_boot_loader
	import boot_loader_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic coef_clk,
	input wire reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	output spi_pins_s spi_out,
	input wire logic spi_miso,
	output logic coef_from_eeprom,
	output logic [COEF_W-1:0] coef_data,
	output logic coef_valid,
	input wire logic coef_ready
);

	typedef struct packed {
		ld_state_e st;
		logic [CLK_SEL_W-1:0] clk_sel;
		logic [CTRL_USED_W-1:0] ctrl;
		logic [7:0] opcode;
		logic [7:0] addr_hi;
		logic [7:0] addr_mid;
		logic [7:0] addr_lo;
		logic done;
		logic crc_err;
		logic [7:0] rdata;
		logic src_prev;
		logic from_eeprom;
		logic cfg_edge;
		logic cfg_lsb;
		logic cfg_wide;
		logic [4:0] cfg_half;
		logic [4:0] half_cnt;
		logic phase;
		logic [2:0] bit_cnt;
		logic [1:0] byte_idx;
		logic [15:0] data_cnt;
		logic [7:0] sh;
		logic [7:0] rx;
		logic [7:0] crc;
		logic sck;
		logic cs_n;
		logic mosi;
		logic push;
		logic [7:0] push_data;
		logic miso_s1;
		logic miso_s2;
	} ld_s;

	ld_s q;
	ld_s d;
	logic fifo_in_ready;

	function automatic logic [4:0] half_reload(input logic [1:0] rate);
		logic [4:0] h;
		h = HALF_R0;
		unique case (rate)
			2'd0: h = HALF_R0;
			2'd1: h = HALF_R1;
			2'd2: h = HALF_R2;
			2'd3: h = HALF_R3;
		endcase
		return h;
	endfunction : half_reload

	function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++)
			r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
		return r;
	endfunction : crc8_step

	function automatic logic tx_bit(input logic lsb, input logic [7:0] sh);
		return lsb ? sh[0] : sh[7];
	endfunction : tx_bit

	function automatic logic [7:0] tx_shift(input logic lsb, input logic [7:0] sh);
		return lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
	endfunction : tx_shift

	// address byte that follows the byte at index idx
	function automatic logic [7:0] next_addr(input logic wide, input logic [1:0] idx,
		input logic [7:0] hi, input logic [7:0] mid, input logic [7:0] lo);
		logic [7:0] a;
		a = lo;
		if (wide)
		begin
			if (idx == 2'd0)
				a = hi;
			else if (idx == 2'd1)
				a = mid;
		end
		else if (idx == 2'd0)
			a = mid;
		return a;
	endfunction : next_addr

	always_comb
	begin
		logic [7:0] nrx;
		logic [7:0] nsh;
		logic smp;
		logic byte_end;
		logic src;
		logic [1:0] last_idx;
		nrx = q.rx;
		nsh = q.sh;
		smp = 1'b0;
		byte_end = 1'b0;
		src = q.ctrl[CTRL_SRC_BIT];
		last_idx = q.cfg_wide ? 2'd3 : 2'd2;
		d = q;
		d.push = 1'b0;
		d.miso_s1 = spi_miso;
		d.miso_s2 = q.miso_s1;
		d.src_prev = src;
		d.from_eeprom = src;

		// register writes; the status register and unmapped offsets ignore them
		if (reg_req.wr)
		begin
			case (reg_req.addr)
				ADDR_SERIAL_CLOCK_SELECT: d.clk_sel = reg_req.wdata[CLK_SEL_LSB +: CLK_SEL_W];
				ADDR_BOOT_LOAD_CONTROL: d.ctrl = reg_req.wdata[CTRL_USED_W-1:0];
				ADDR_BOOT_READ_OPCODE: d.opcode = reg_req.wdata;
				ADDR_BOOT_START_ADDR_HIGH: d.addr_hi = reg_req.wdata;
				ADDR_BOOT_START_ADDR_MID: d.addr_mid = reg_req.wdata;
				ADDR_BOOT_START_ADDR_LOW: d.addr_lo = reg_req.wdata;
				default: d.rdata = q.rdata;
			endcase
		end

		// register reads, held until the next read; unmapped reads return zero
		if (reg_req.rd)
		begin
			case (reg_req.addr)
				ADDR_SERIAL_CLOCK_SELECT: d.rdata = {4'h0, q.clk_sel};
				ADDR_BOOT_LOAD_CONTROL: d.rdata = {2'h0, q.ctrl};
				ADDR_BOOT_READ_OPCODE: d.rdata = q.opcode;
				ADDR_BOOT_START_ADDR_HIGH: d.rdata = q.addr_hi;
				ADDR_BOOT_START_ADDR_MID: d.rdata = q.addr_mid;
				ADDR_BOOT_START_ADDR_LOW: d.rdata = q.addr_lo;
				ADDR_BOOT_LOAD_STATUS: d.rdata = {6'h00, q.crc_err, q.done};
				default: d.rdata = 8'h00;
			endcase
		end

		unique case (q.st)
			LD_IDLE:
			begin
				d.cs_n = 1'b1;
				// a rising source select bit starts one load
				if (src && !q.src_prev)
				begin
					d.cfg_edge = q.ctrl[CTRL_EDGE_BIT];
					d.cfg_lsb = q.ctrl[CTRL_ORDER_BIT];
					d.cfg_wide = q.ctrl[CTRL_WIDE_BIT];
					d.cfg_half = half_reload(q.ctrl[CTRL_RATE_LSB +: 2]);
					d.half_cnt = half_reload(q.ctrl[CTRL_RATE_LSB +: 2]);
					d.done = 1'b0;
					d.crc_err = 1'b0;
					d.cs_n = 1'b0;
					d.st = LD_SEND;
					d.sh = q.opcode;
					d.byte_idx = 2'd0;
					d.bit_cnt = 3'd0;
					d.phase = 1'b0;
					d.data_cnt = 16'h0000;
					d.crc = CRC_INIT;
					d.mosi = q.ctrl[CTRL_EDGE_BIT] ? tx_bit(q.ctrl[CTRL_ORDER_BIT], q.opcode) : 1'b0;
				end
			end
			LD_SEND, LD_RECV:
			begin
				if (!src)
				begin
					d.st = LD_FINISH;
					d.sck = 1'b0;
				end
				else if (q.half_cnt != 5'h00)
					d.half_cnt = q.half_cnt - 5'h01;
				else
				begin
					d.half_cnt = q.cfg_half;
					if (!q.phase)
					begin
						d.sck = 1'b1;
						d.phase = 1'b1;
						if (!q.cfg_edge)
							d.mosi = (q.st == LD_SEND) ? tx_bit(q.cfg_lsb, q.sh) : 1'b0;
						else
							smp = 1'b1;
					end
					else
					begin
						d.sck = 1'b0;
						d.phase = 1'b0;
						if (!q.cfg_edge)
							smp = 1'b1;
						nsh = tx_shift(q.cfg_lsb, q.sh);
						d.sh = nsh;
						if (q.bit_cnt != 3'd7)
						begin
							d.bit_cnt = q.bit_cnt + 3'd1;
							if (q.cfg_edge)
								d.mosi = (q.st == LD_SEND) ? tx_bit(q.cfg_lsb, nsh) : 1'b0;
						end
						else
						begin
							d.bit_cnt = 3'd0;
							byte_end = 1'b1;
						end
					end
				end
			end
			LD_HOLD:
			begin
				// wait for buffer room before clocking in the next byte
				if (!src)
					d.st = LD_FINISH;
				else if (fifo_in_ready && !q.push)
				begin
					d.st = LD_RECV;
					d.half_cnt = q.cfg_half;
					d.phase = 1'b0;
					d.bit_cnt = 3'd0;
					d.sh = 8'h00;
					d.mosi = 1'b0;
				end
			end
			LD_FINISH:
			begin
				d.cs_n = 1'b1;
				d.mosi = 1'b0;
				d.sck = 1'b0;
				d.st = LD_IDLE;
			end
			default:
				d.st = LD_IDLE;
		endcase

		if (smp)
		begin
			nrx = q.cfg_lsb ? {q.miso_s2, q.rx[7:1]} : {q.rx[6:0], q.miso_s2};
			d.rx = nrx;
		end

		if (byte_end && q.st == LD_SEND)
		begin
			if (q.byte_idx == last_idx)
			begin
				d.st = LD_HOLD;
			end
			else
			begin
				d.byte_idx = q.byte_idx + 2'd1;
				nsh = next_addr(q.cfg_wide, q.byte_idx, q.addr_hi, q.addr_mid, q.addr_lo);
				d.sh = nsh;
				if (q.cfg_edge)
					d.mosi = tx_bit(q.cfg_lsb, nsh);
			end
		end
		else if (byte_end && q.st == LD_RECV)
		begin
			if (q.data_cnt != IMAGE_LEN)
			begin
				d.push = 1'b1;
				d.push_data = nrx;
				d.crc = crc8_step(q.crc, nrx);
				d.data_cnt = q.data_cnt + 16'h0001;
				d.st = LD_HOLD;
			end
			else
			begin
				d.crc_err = nrx != q.crc;
				d.done = 1'b1;
				d.st = LD_FINISH;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			q <= '0;
			q.st <= LD_IDLE;
			q.clk_sel <= RST_SERIAL_CLOCK_SELECT[CLK_SEL_W-1:0];
			q.ctrl <= RST_BOOT_LOAD_CONTROL[CTRL_USED_W-1:0];
			q.opcode <= RST_BOOT_READ_OPCODE;
			q.addr_hi <= RST_BOOT_START_ADDR;
			q.addr_mid <= RST_BOOT_START_ADDR;
			q.addr_lo <= RST_BOOT_START_ADDR;
			q.cfg_half <= HALF_R0;
			q.half_cnt <= HALF_R0;
			q.crc <= CRC_INIT;
			q.cs_n <= 1'b1;
		end
		else
			q <= d;
	end

	coef_async_fifo #(
		.WIDTH(COEF_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.wr_clk(mclk),
		.wr_rst(rst),
		.in_valid(q.push),
		.in_data(q.push_data),
		.in_ready(fifo_in_ready),
		.rd_clk(coef_clk),
		.out_valid(coef_valid),
		.out_data(coef_data),
		.out_ready(coef_ready)
	);

	assign reg_rdata = q.rdata;
	assign spi_out.sck = q.sck;
	assign spi_out.cs_n = q.cs_n;
	assign spi_out.mosi = q.mosi;
	assign coef_from_eeprom = q.from_eeprom;

endmodule : eeprom_boot_loader
